/* verilog/logic_cell_defs.vh */
// Constants for the programmable logic cell datapath
`ifndef LOGIC_CELL_DEFS_VH
`define LOGIC_CELL_DEFS_VH
// Working register addresses on the system bus
`define ADDR_ACC0     3'h0
`define ADDR_ACC1     3'h1
`define ADDR_OPR0     3'h2
`define ADDR_OPR1     3'h3
`define ADDR_QUE0     3'h4
`define ADDR_QUE1     3'h5
`define ADDR_STATUS   3'h6
// Reset values
`define RST_BYTE      8'h00
`define RST_CFG       16'h0000
// Configuration word fields
`define CF_FUNC_LO    0
`define CF_FUNC_HI    2
`define CF_SRCA_LO    3
`define CF_SRCA_HI    4
`define CF_SRCB_LO    5
`define CF_SRCB_HI    6
`define CF_SHFT_LO    7
`define CF_SHFT_HI    8
`define CF_MASK       9
`define CF_WR_ACC0    10
`define CF_WR_ACC1    11
`define CF_CAP_QUE0   12
`define CF_CAP_QUE1   13
`define CF_CRC        14
`define CF_LOAD_QUE   15
// Operations
`define OP_PASS       3'h0
`define OP_INC        3'h1
`define OP_DEC        3'h2
`define OP_ADD        3'h3
`define OP_SUB        3'h4
`define OP_AND        3'h5
`define OP_OR         3'h6
`define OP_XOR        3'h7
// Shift modes
`define SH_NONE       2'h0
`define SH_LEFT       2'h1
`define SH_RIGHT      2'h2
`define SH_SWAP       2'h3
// Sizes
`define DATA_W        8
`define CFG_W         16
`define CFG_DEPTH     8
`define QUE_DEPTH     4
`define ARR_IN        12
`define ARR_PT        8
`define ARR_OUT       4
`define COND_N        16
`define COND_OUT      6
`endif

/* verilog/config_ram.v */
// Eight-word configuration memory with registered read
`timescale 1ns/1ns
`include "logic_cell_defs.vh"
module config_ram
(
  input  wire              clk,
  input  wire              rst,
  input  wire              wrEn,
  input  wire [2:0]        wrAddr,
  input  wire [15:0]       wrData,
  input  wire [2:0]        rdAddr,
  output reg  [15:0]       rdData
);
  reg [15:0] mem [0:`CFG_DEPTH-1];
  always @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end
  always @(posedge clk)
  begin
    if (rst)
      rdData <= `RST_CFG;
    else
      rdData <= mem[rdAddr];
  end
endmodule // config_ram

/* verilog/logic_cell.v */
// Logic cell: two sum-of-products arrays and an 8-bit datapath
`timescale 1ns/1ns
`include "logic_cell_defs.vh"
module logic_cell
(
  input  wire              clk,
  input  wire              rst,
  // Sum-of-products arrays
  input  wire [23:0]       arrIn,
  input  wire [191:0]      arrTrueSel0,
  input  wire [191:0]      arrCompSel0,
  input  wire [31:0]       arrOrSel0,
  input  wire [3:0]        arrRegSel0,
  input  wire [191:0]      arrTrueSel1,
  input  wire [191:0]      arrCompSel1,
  input  wire [31:0]       arrOrSel1,
  input  wire [3:0]        arrRegSel1,
  output wire [7:0]        arrOut,
  // System bus
  input  wire              busWr,
  input  wire              busRd,
  input  wire [2:0]        busAddr,
  input  wire [7:0]        busWdata,
  output reg  [7:0]        busRdata,
  // Configuration memory
  input  wire              cfgWr,
  input  wire [2:0]        cfgWrAddr,
  input  wire [15:0]       cfgWrData,
  input  wire [2:0]        cfgAddr,
  // Static datapath options
  input  wire [2:0]        msbSel,
  input  wire [7:0]        orMask,
  input  wire [7:0]        polynomial,
  input  wire [7:0]        cmpMask0,
  input  wire [7:0]        cmpMask1,
  input  wire              cmpSwap0,
  input  wire              cmpSwap1,
  input  wire              que0Out,
  input  wire              que1Out,
  input  wire              queToAcc,
  input  wire              capAcc,
  input  wire [23:0]       condSel,
  // Chaining
  input  wire              chainEn,
  input  wire              chainCarryIn,
  input  wire              chainShiftIn,
  input  wire              chainEq0In,
  input  wire              chainLt0In,
  input  wire              chainEq1In,
  input  wire              chainLt1In,
  output reg               chainCarryOut,
  output reg               chainShiftOut,
  output reg               chainEq0Out,
  output reg               chainLt0Out,
  output reg               chainEq1Out,
  output reg               chainLt1Out,
  // Conditions to the fabric
  output reg  [5:0]        condOut
);
  //--------------------------------------------
  // Helper functions
  //--------------------------------------------
  function [7:0] msbMask;
    input [2:0] m;
    msbMask = 8'hFF >> (3'h7 - m);
  endfunction

  function pick;
    input [15:0] c;
    input [3:0]  s;
    pick = c[s];
  endfunction

  function [7:0] srcMux;
    input [1:0] s;
    input [7:0] a0;
    input [7:0] a1;
    input [7:0] d0;
    input [7:0] d1;
    case (s)
      2'h0: srcMux = a0;
      2'h1: srcMux = a1;
      2'h2: srcMux = d0;
      default: srcMux = d1;
    endcase
  endfunction

  //--------------------------------------------
  // Sum-of-products arrays
  //--------------------------------------------
  wire [7:0]  arrComb;
  reg  [7:0]  arrReg_ff;
  wire [15:0] ptTerm;
  genvar ga;
  genvar gp;
  genvar go;
  generate
    for (ga = 0; ga < 2; ga = ga + 1)
    begin : gArr
      wire [191:0] tSel = (ga == 0) ? arrTrueSel0 : arrTrueSel1;
      wire [191:0] cSel = (ga == 0) ? arrCompSel0 : arrCompSel1;
      wire [31:0]  oSel = (ga == 0) ? arrOrSel0 : arrOrSel1;
      wire [11:0]  in   = arrIn[ga*12 +: 12];
      for (gp = 0; gp < `ARR_PT; gp = gp + 1)
      begin : gPt
        // AND of any chosen true or complement inputs
        assign ptTerm[ga*8+gp] = &((in | ~tSel[gp*12 +: 12])
                                 & (~in | ~cSel[gp*12 +: 12]))
                                 & |(tSel[gp*12 +: 12] | cSel[gp*12 +: 12]);
      end
      for (go = 0; go < `ARR_OUT; go = go + 1)
      begin : gOut
        assign arrComb[ga*4+go] = |(ptTerm[ga*8 +: 8] & oSel[go*8 +: 8]);
      end
    end
  endgenerate

  always @(posedge clk)
  begin
    if (rst)
      arrReg_ff <= `RST_BYTE;
    else
      arrReg_ff <= arrComb;
  end
  // Each output registered or direct
  assign arrOut = ({arrRegSel1, arrRegSel0} & arrReg_ff)
                | (~{arrRegSel1, arrRegSel0} & arrComb);

  //--------------------------------------------
  // Configuration memory
  //--------------------------------------------
  wire [15:0] cfg;
  config_ram uCfg
  (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (cfgWr),
    .wrAddr (cfgWrAddr),
    .wrData (cfgWrData),
    .rdAddr (cfgAddr),
    .rdData (cfg)
  );

  //--------------------------------------------
  // Working registers and queues
  //--------------------------------------------
  reg  [7:0] acc0_ff;
  reg  [7:0] acc1_ff;
  reg  [7:0] opr0_ff;
  reg  [7:0] opr1_ff;
  reg  [7:0] que0_ff [0:3];
  reg  [7:0] que1_ff [0:3];
  reg  [1:0] q0Wp_ff;
  reg  [1:0] q0Rp_ff;
  reg  [2:0] q0Cnt_ff;
  reg  [1:0] q1Wp_ff;
  reg  [1:0] q1Rp_ff;
  reg  [2:0] q1Cnt_ff;
  wire q0Empty = (q0Cnt_ff == 3'h0);
  wire q0Full  = (q0Cnt_ff == 3'h4);
  wire q1Empty = (q1Cnt_ff == 3'h0);
  wire q1Full  = (q1Cnt_ff == 3'h4);

  //--------------------------------------------
  // ALU, shifter, mask and CRC step
  //--------------------------------------------
  wire [7:0] msk  = msbMask(msbSel);
  wire [7:0] opA  = srcMux(cfg[`CF_SRCA_HI:`CF_SRCA_LO], acc0_ff, acc1_ff, opr0_ff, opr1_ff);
  wire [7:0] opB  = srcMux(cfg[`CF_SRCB_HI:`CF_SRCB_LO], acc0_ff, acc1_ff, opr0_ff, opr1_ff);
  wire       cin  = chainEn & chainCarryIn;
  reg  [8:0] sum;
  reg  [7:0] aluRes;
  reg  [7:0] shRes;
  reg  [7:0] dpRes;
  reg        carry;
  reg        ovf;
  reg        shOut;
  reg        fb;
  always @*
  begin
    sum = 9'h000;
    case (cfg[`CF_FUNC_HI:`CF_FUNC_LO])
      `OP_INC: sum = {1'b0, opA} + 9'h001;
      `OP_DEC: sum = {1'b0, opA} - 9'h001;
      `OP_ADD: sum = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
      `OP_SUB: sum = {1'b0, opA} - {1'b0, opB};
      `OP_AND: sum = {1'b0, opA & opB};
      `OP_OR:  sum = {1'b0, opA | opB};
      `OP_XOR: sum = {1'b0, opA ^ opB};
      default: sum = {1'b0, opA};
    endcase
    aluRes = sum[7:0] & msk;
    carry  = (msbSel == 3'h7) ? sum[8] : sum[msbSel + 3'h1];
    ovf    = (opA[msbSel] == opB[msbSel]) & (aluRes[msbSel] != opA[msbSel])
           & (cfg[`CF_FUNC_HI:`CF_FUNC_LO] == `OP_ADD);
    shOut  = 1'b0;
    shRes  = aluRes;
    case (cfg[`CF_SHFT_HI:`CF_SHFT_LO])
      `SH_LEFT:
      begin
        shOut = aluRes[msbSel];
        shRes = {aluRes[6:0], chainShiftIn} & msk;
      end
      `SH_RIGHT:
      begin
        shOut = aluRes[0];
        shRes = (aluRes >> 1) | ({7'h00, chainShiftIn} << msbSel);
      end
      `SH_SWAP: shRes = {aluRes[3:0], aluRes[7:4]};
      default: shRes = aluRes;
    endcase
    // Galois step: MSB out xor serial in decides polynomial feedback
    fb = opA[msbSel] ^ chainShiftIn;
    if (cfg[`CF_CRC])
    begin
      shOut = opA[msbSel];
      shRes = (({opA[6:0], 1'b0}) ^ (fb ? polynomial : 8'h00)) & msk;
    end
    dpRes = cfg[`CF_MASK] ? (shRes | orMask) : shRes;
  end

  //--------------------------------------------
  // Queue moves
  //--------------------------------------------
  wire busW0 = busWr & (busAddr == `ADDR_QUE0);
  wire busW1 = busWr & (busAddr == `ADDR_QUE1);
  wire busR0 = busRd & (busAddr == `ADDR_QUE0);
  wire busR1 = busRd & (busAddr == `ADDR_QUE1);
  wire [7:0] capVal0 = capAcc ? acc0_ff : dpRes;
  wire [7:0] capVal1 = capAcc ? acc1_ff : dpRes;
  wire push0 = que0Out ? (cfg[`CF_CAP_QUE0] & ~q0Full) : (busW0 & ~q0Full);
  wire push1 = que1Out ? (cfg[`CF_CAP_QUE1] & ~q1Full) : (busW1 & ~q1Full);
  wire pop0  = que0Out ? (busR0 & ~q0Empty) : (cfg[`CF_LOAD_QUE] & ~q0Empty);
  wire pop1  = que1Out ? (busR1 & ~q1Empty) : (cfg[`CF_LOAD_QUE] & ~q1Empty);
  wire [7:0] q0Head = que0_ff[q0Rp_ff];
  wire [7:0] q1Head = que1_ff[q1Rp_ff];
  wire ld0 = pop0 & ~que0Out;
  wire ld1 = pop1 & ~que1Out;

  always @(posedge clk)
  begin
    if (push0)
      que0_ff[q0Wp_ff] <= que0Out ? capVal0 : busWdata;
    if (push1)
      que1_ff[q1Wp_ff] <= que1Out ? capVal1 : busWdata;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      q0Wp_ff  <= 2'h0;
      q0Rp_ff  <= 2'h0;
      q0Cnt_ff <= 3'h0;
      q1Wp_ff  <= 2'h0;
      q1Rp_ff  <= 2'h0;
      q1Cnt_ff <= 3'h0;
    end
    else
    begin
      q0Wp_ff  <= q0Wp_ff + {1'b0, push0};
      q0Rp_ff  <= q0Rp_ff + {1'b0, pop0};
      q0Cnt_ff <= q0Cnt_ff + {2'h0, push0} - {2'h0, pop0};
      q1Wp_ff  <= q1Wp_ff + {1'b0, push1};
      q1Rp_ff  <= q1Rp_ff + {1'b0, pop1};
      q1Cnt_ff <= q1Cnt_ff + {2'h0, push1} - {2'h0, pop1};
    end
  end

  //--------------------------------------------
  // Working register updates
  //--------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      acc0_ff <= `RST_BYTE;
      acc1_ff <= `RST_BYTE;
      opr0_ff <= `RST_BYTE;
      opr1_ff <= `RST_BYTE;
    end
    else
    begin
      // Bus write has priority over datapath update
      if (busWr & (busAddr == `ADDR_ACC0))
        acc0_ff <= busWdata;
      else if (ld0 & queToAcc)
        acc0_ff <= q0Head;
      else if (cfg[`CF_WR_ACC0])
        acc0_ff <= dpRes;
      if (busWr & (busAddr == `ADDR_ACC1))
        acc1_ff <= busWdata;
      else if (ld1 & queToAcc)
        acc1_ff <= q1Head;
      else if (cfg[`CF_WR_ACC1])
        acc1_ff <= dpRes;
      if (busWr & (busAddr == `ADDR_OPR0))
        opr0_ff <= busWdata;
      else if (ld0 & ~queToAcc)
        opr0_ff <= q0Head;
      if (busWr & (busAddr == `ADDR_OPR1))
        opr1_ff <= busWdata;
      else if (ld1 & ~queToAcc)
        opr1_ff <= q1Head;
    end
  end

  //--------------------------------------------
  // Bus read
  //--------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
      busRdata <= `RST_BYTE;
    else if (busRd)
    begin
      case (busAddr)
        `ADDR_ACC0:   busRdata <= acc0_ff;
        `ADDR_ACC1:   busRdata <= acc1_ff;
        `ADDR_OPR0:   busRdata <= opr0_ff;
        `ADDR_OPR1:   busRdata <= opr1_ff;
        `ADDR_QUE0:   busRdata <= q0Head;
        `ADDR_QUE1:   busRdata <= q1Head;
        `ADDR_STATUS: busRdata <= {4'h0, q1Full, q1Empty, q0Full, q0Empty};
        default:      busRdata <= `RST_BYTE;
      endcase
    end
  end

  //--------------------------------------------
  // Compares and conditions
  //--------------------------------------------
  wire [7:0] c0a  = (cmpSwap0 ? acc1_ff : acc0_ff) & cmpMask0;
  wire [7:0] c0b  = (cmpSwap0 ? opr1_ff : opr0_ff) & cmpMask0;
  wire [7:0] c1a  = (cmpSwap1 ? acc0_ff : acc1_ff) & cmpMask1;
  wire [7:0] c1b  = (cmpSwap1 ? acc1_ff : opr1_ff) & cmpMask1;
  wire eq0  = (c0a == c0b) & (~chainEn | chainEq0In);
  wire lt0  = (c0a < c0b) | (chainEn & (c0a == c0b) & chainLt0In);
  wire eq1  = (c1a == c1b) & (~chainEn | chainEq1In);
  wire lt1  = (c1a < c1b) | (chainEn & (c1a == c1b) & chainLt1In);
  wire z0   = ((acc0_ff & msk) == 8'h00);
  wire z1   = ((acc1_ff & msk) == 8'h00);
  wire f0   = ((acc0_ff & msk) == msk);
  wire f1   = ((acc1_ff & msk) == msk);
  wire [15:0] conds = {shOut, carry, q1Full, q1Empty, q0Full, q0Empty,
                       ovf, f1, f0, z1, z0, lt1, eq1, lt0, eq0, 1'b0};
  integer k;
  reg [5:0] nxt_cond;
  always @*
  begin
    nxt_cond = 6'h00;
    for (k = 0; k < `COND_OUT; k = k + 1)
      nxt_cond[k] = pick(conds, condSel[k*4 +: 4]);
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      condOut       <= 6'h00;
      chainCarryOut <= 1'b0;
      chainShiftOut <= 1'b0;
      chainEq0Out   <= 1'b0;
      chainLt0Out   <= 1'b0;
      chainEq1Out   <= 1'b0;
      chainLt1Out   <= 1'b0;
    end
    else
    begin
      condOut       <= nxt_cond;
      chainCarryOut <= carry;
      chainShiftOut <= shOut;
      chainEq0Out   <= eq0;
      chainLt0Out   <= lt0;
      chainEq1Out   <= eq1;
      chainLt1Out   <= lt1;
    end
  end
endmodule // logic_cell

/* test/cpu_bus_model.sv */
// CPU master model driving the working register bus
`timescale 1ns/1ns
module cpu_bus_model
(
  input  wire       clk,
  input  wire [7:0] busRdata,
  output reg        busWr,
  output reg        busRd,
  output reg  [2:0] busAddr,
  output reg  [7:0] busWdata
);
  // --------------------------------
  // Idle bus
  // --------------------------------
  initial
  begin
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = 3'h7;
    busWdata = 8'h00;
  end
  // --------------------------------
  // One byte transfer, strobe held over one edge
  // --------------------------------
  task automatic xfer(input bit wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
  begin
    @(negedge clk);
    busWr = wr;
    busRd = !wr;
    busAddr = a;
    busWdata = d;
    @(posedge clk);
    @(negedge clk);
    q = busRdata;
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = ~a;
    busWdata = ~d;
  end
  endtask
endmodule // cpu_bus_model

/* test/logic_cell_checker.sv */
// Port assertions for the logic cell
`timescale 1ns/1ns
module logic_cell_checker
(
  input wire         clk,
  input wire         rst,
  input wire [23:0]  arrIn,
  input wire [191:0] arrTrueSel0,
  input wire [191:0] arrCompSel0,
  input wire [31:0]  arrOrSel0,
  input wire [3:0]   arrRegSel0,
  input wire [7:0]   arrOut,
  input wire         busWr,
  input wire         busRd,
  input wire [2:0]   busAddr,
  input wire [7:0]   busWdata,
  input wire [7:0]   busRdata,
  input wire         que1Out,
  input wire [23:0]  condSel,
  input wire [5:0]   condOut,
  input wire         chainCarryOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire termT = arrTrueSel0 == 192'h1 && arrCompSel0 == 192'h0 && arrOrSel0[7:0] == 8'h01;
  wire termC = arrCompSel0 == 192'h1 && arrTrueSel0 == 192'h0 && arrOrSel0[7:0] == 8'h01;
  // --------------------------------
  // Assertions
  // --------------------------------
  chk_arr_true_comb: assert property (termT && !arrRegSel0[0] |-> arrOut[0] == arrIn[0])
    else $error("true term output wrong");
  chk_arr_comp_comb: assert property (termC && !arrRegSel0[0] |-> arrOut[0] == !arrIn[0])
    else $error("complement term output wrong");
  chk_arr_true_reg: assert property ((termT && arrRegSel0[0]) [*2] |-> arrOut[0] == $past(arrIn[0]))
    else $error("registered term output wrong");
  chk_rd_spare_zero: assert property (busRd && busAddr == 3'h7 |=> busRdata == 8'h00)
    else $error("spare address read not zero");
  chk_rdata_holds: assert property (!busRd |=> $stable(busRdata))
    else $error("read data changed without a read");
  chk_opr_readback: assert property (busWr && busAddr == 3'h3 && que1Out ##2 busRd && busAddr == 3'h3 && que1Out
    |=> busRdata == $past(busWdata, 3))
    else $error("operand register readback wrong");
  chk_status_shape: assert property (busRd && busAddr == 3'h6 |=> busRdata[7:4] == 4'h0
    && !(busRdata[0] && busRdata[1]) && !(busRdata[2] && busRdata[3]))
    else $error("queue status inconsistent");
  chk_cond_const: assert property ($past(condSel[3:0]) == 4'h0 |-> condOut[0] == 1'b0)
    else $error("constant condition not zero");
  chk_reset_values: assert property ($fell(rst) |-> busRdata == 8'h00 && condOut == 6'h00 && !chainCarryOut)
    else $error("outputs not cleared by reset");
  cover property (busWr && busAddr == 3'h4);
  cover property (busRd && busAddr == 3'h5);
  cover property (termT && arrRegSel0[0]);
endmodule // logic_cell_checker
bind logic_cell logic_cell_checker logic_cell_checker_inst
(
  .clk(clk), .rst(rst), .arrIn(arrIn), .arrTrueSel0(arrTrueSel0), .arrCompSel0(arrCompSel0),
  .arrOrSel0(arrOrSel0), .arrRegSel0(arrRegSel0), .arrOut(arrOut), .busWr(busWr), .busRd(busRd),
  .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .que1Out(que1Out), .condSel(condSel),
  .condOut(condOut), .chainCarryOut(chainCarryOut)
);

/* test/tb_top.sv */
// Self-checking bench for the logic cell
`timescale 1ns/1ns
module tb_top;
  reg          clk;
  reg          rst;
  reg  [23:0]  arrIn;
  reg  [191:0] trueSel;
  reg  [191:0] compSel;
  reg  [3:0]   regSel;
  reg          cfgWr;
  reg  [2:0]   cfgWrAddr;
  reg  [15:0]  cfgWrData;
  reg  [2:0]   cfgAddr;
  reg  [7:0]   orMask;
  reg  [31:0]  misc;
  reg  [31:0]  seed;
  wire [7:0]   arrOut;
  wire [7:0]   busRdata;
  wire [7:0]   busWdata;
  wire [2:0]   busAddr;
  wire         busWr;
  wire         busRd;
  wire [5:0]   condOut;
  reg  [2:0]   msbSel;
  reg  [23:0]  condSel;
  reg          queToAcc;
  reg          capAcc;
  wire         eqOut;
  wire         shiftOut;
  logic [7:0]  r [4];
  logic [7:0]  got;
  logic [7:0]  q [$];
  int          numErrors;
  int          nCompared;
  logic_cell logic_cell_inst
  (
    .clk(clk), .rst(rst), .arrIn(arrIn), .arrTrueSel0(trueSel), .arrCompSel0(compSel), .arrOrSel0(32'h00000001),
    .arrRegSel0(regSel), .arrTrueSel1(compSel), .arrCompSel1(trueSel), .arrOrSel1({misc[31:8], 8'h01}),
    .arrRegSel1(regSel), .arrOut(arrOut), .busWr(busWr), .busRd(busRd), .busAddr(busAddr), .busWdata(busWdata),
    .busRdata(busRdata), .cfgWr(cfgWr), .cfgWrAddr(cfgWrAddr), .cfgWrData(cfgWrData), .cfgAddr(cfgAddr),
    .msbSel(msbSel), .orMask(orMask), .polynomial(misc[15:8]), .cmpMask0(misc[23:16]), .cmpMask1(misc[31:24]),
    .cmpSwap0(misc[2]), .cmpSwap1(misc[3]), .que0Out(1'b0), .que1Out(1'b1), .queToAcc(queToAcc), .capAcc(capAcc),
    .condSel(condSel), .chainEn(1'b0), .chainCarryIn(misc[0]), .chainShiftIn(misc[1]), .chainEq0In(misc[4]),
    .chainLt0In(misc[5]), .chainEq1In(misc[6]), .chainLt1In(misc[7]), .chainCarryOut(), .chainShiftOut(shiftOut),
    .chainEq0Out(eqOut), .chainLt0Out(), .chainEq1Out(), .chainLt1Out(), .condOut(condOut)
  );
  cpu_bus_model cpu_bus_model_inst
  (
    .clk(clk), .busRdata(busRdata), .busWr(busWr), .busRd(busRd), .busAddr(busAddr), .busWdata(busWdata)
  );
  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] model(int op, int sh, int a, int b, bit msk);
    int v;
    case (op)
      0: v = a;
      1: v = a + 1;
      2: v = a - 1;
      3: v = a + b;
      4: v = a - b;
      5: v = a & b;
      6: v = a | b;
      default: v = a ^ b;
    endcase
    v = v & 255;
    if (sh == 1) v = ((v << 1) | misc[1]) & 255;
    if (sh == 2) v = (v >> 1) | (misc[1] << 7);
    if (sh == 3) v = ((v << 4) | (v >> 4)) & 255;
    if (msk) v = v | orMask;
    return v[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpu_bus_model_inst.xfer(1'b1, a, d, got);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    cpu_bus_model_inst.xfer(1'b0, a, 8'h00, got);
    check(got, e);
  endtask
  task automatic write_cfg(input logic [2:0] k, input logic [15:0] w);
    @(negedge clk);
    cfgWr = 1'b1;
    cfgWrAddr = k;
    cfgWrData = w;
    @(negedge clk);
    cfgWr = 1'b0;
  endtask
  task automatic run_word(input logic [2:0] k);
    @(negedge clk);
    cfgAddr = k;
    @(negedge clk);
    cfgAddr = 3'h0;
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // --------------------------------
  // Clock, watchdog and tests
  // --------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    numErrors++;
    summarize();
  end
  initial
  begin
    rst = 1'b1;
    seed = 32'h00024F07;
    misc = rnd();
    arrIn = 24'h000000;
    trueSel = 192'h1;
    compSel = 192'h0;
    regSel = 4'h0;
    cfgWr = 1'b1;
    cfgWrAddr = 3'h0;
    cfgWrData = 16'h0000;
    cfgAddr = 3'h0;
    orMask = 8'h00;
    msbSel = 3'h7;
    condSel = 24'h0001A0;
    queToAcc = 1'b0;
    capAcc = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cfgWr = 1'b0;
    for (int a = 0; a < 8; a++)
      if (a != 4 && a != 5) rd(a, a == 6 ? 8'h05 : 8'h00);
    check({7'h0, condOut[1]}, 8'h01);
    for (int a = 0; a < 4; a++)
    begin
      r[a] = rnd();
      wr(a, r[a]);
      rd(a, r[a]);
    end
    for (int i = 0; i < 16; i++)
    begin
      r[0] = rnd();
      r[2] = rnd();
      orMask = rnd();
      wr(0, r[0]);
      wr(2, r[2]);
      write_cfg(3'h1, 16'h0840 | (i % 8) | ((i / 4) << 7) | ((i >= 12) << 9));
      run_word(3'h1);
      rd(1, model(i % 8, i / 4, r[0], r[2], i >= 12));
    end
    for (int i = 0; i < 5; i++)
    begin
      r[2] = rnd();
      wr(4, r[2]);
      if (i < 4) q.push_back(r[2]);
    end
    rd(6, 8'h06);
    check({7'h0, condOut[1]}, 8'h00);
    write_cfg(3'h2, 16'h8000);
    while (q.size() > 0)
    begin
      run_word(3'h2);
      rd(2, q.pop_front());
    end
    write_cfg(3'h3, 16'h2000);
    for (int i = 0; i < 5; i++)
    begin
      r[0] = rnd();
      wr(0, r[0]);
      run_word(3'h3);
      if (i < 4) q.push_back(r[0]);
    end
    rd(6, 8'h09);
    while (q.size() > 0) rd(5, q.pop_front());
    rd(6, 8'h05);
    queToAcc = 1'b1;
    r[1] = rnd();
    wr(4, r[1]);
    run_word(3'h2);
    rd(0, r[1]);
    capAcc = 1'b1;
    r[2] = rnd();
    wr(1, r[2]);
    run_word(3'h3);
    rd(5, r[2]);
    r[0] = rnd();
    for (int a = 0; a < 4; a++) wr(a, r[0]);
    rd(3, r[0]);
    check({7'h0, condOut[2]}, 8'h01);
    check({7'h0, eqOut}, 8'h01);
    wr(2, ~r[0]);
    wr(3, ~r[0]);
    rd(2, ~r[0]);
    check({7'h0, condOut[2]}, {7'h0, misc[23:16] == 8'h00});
    check({7'h0, eqOut}, {7'h0, misc[23:16] == 8'h00});
    msbSel = 3'h3;
    write_cfg(3'h4, 16'h4400);
    r[0] = rnd();
    wr(0, r[0]);
    run_word(3'h4);
    check({7'h0, shiftOut}, {7'h0, r[0][3]});
    rd(0, ((r[0] << 1) ^ ((r[0][3] ^ misc[1]) ? misc[15:8] : 8'h00)) & 8'h0F);
    msbSel = 3'h7;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk);
      arrIn = rnd();
      regSel = {3'h0, i >= 4 && i < 8};
      trueSel = i < 8 ? 192'h1 : 192'h0;
      compSel = i < 8 ? 192'h0 : 192'h1;
      #1;
      if (!regSel[0]) check({7'h0, arrOut[0]}, {7'h0, arrIn[0] ^ (i >= 8)});
      if (!regSel[0]) check({7'h0, arrOut[4]}, {7'h0, arrIn[12] ^ (i < 8)});
    end
    summarize();
  end
endmodule // tb_top
